/* hdl/pmrcc_regs.svh */
// Offsets, field positions, reset values and timing figures of the rail and charge controller.
// Assumes a 10 MHz system clock and 32-bit APB data with word-aligned registers.
`ifndef PMRCC_REGS_SVH
`define PMRCC_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PMRCC_CTRL_OFS 12'h000
`define PMRCC_STATUS_OFS 12'h004
`define PMRCC_CTRL_INHIBIT_BIT 0
`define PMRCC_CTRL_RST 32'h0000_0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMRCC_CLK_HZ 10000000
`define PMRCC_RST_DLY_MS 125
`define PMRCC_READY_MS 1
`define PMRCC_PRECHG_S 1800
`define PMRCC_CHG_S 18000
`define PMRCC_RST_DLY_CYC ((`PMRCC_RST_DLY_MS * `PMRCC_CLK_HZ) / 1000)
`define PMRCC_READY_CYC ((`PMRCC_READY_MS * `PMRCC_CLK_HZ) / 1000)
`define PMRCC_PRECHG_CYC (64'(`PMRCC_PRECHG_S) * 64'(`PMRCC_CLK_HZ))
`define PMRCC_CHG_CYC (64'(`PMRCC_CHG_S) * 64'(`PMRCC_CLK_HZ))

`endif

/* hdl/pmrcc_pkg.sv */
// Types shared by the rail and charge controller and its bench.
// Assumes the macros of pmrcc_regs.svh for all numbers.
package pmrcc_pkg;

    // Host-side logic pins
    typedef struct packed {
        logic host_suspend;
        logic main_rail_enable;
        logic aux_rail_enable;
        logic red_led_ctrl;
        logic green_led_ctrl;
        logic blue_led_ctrl;
        logic motor_ctrl;
        logic charge_enable_n;
    } pmrcc_ctl_t;

    // Analog comparator results
    typedef struct packed {
        logic host_power_good;
        logic adapter_power_good;
        logic battery_present;
        logic system_rail_good;
        logic logic_supply_low;
        logic logic_supply_high;
        logic batt_low_v;
        logic batt_at_reg;
        logic batt_below_rch;
        logic charge_term;
    } pmrcc_ana_t;

    typedef struct packed {
        logic logic_supply_en;
        logic logic_discharge_en;
        logic second_reg_en;
        logic third_reg_en;
        logic three_volt_en;
        logic led_supply_en;
        logic boost_run;
        logic linear_run;
    } pmrcc_rail_t;

    typedef struct packed {
        logic host_suspended;
        logic host_feeds;
        logic adapter_feeds;
        logic standby;
        logic batt_low_r_switch;
        logic rails_ready;
    } pmrcc_path_t;

    // Open-drain pin: o is the driven level, oe high while pulling
    typedef struct packed {
        logic o;
        logic oe;
    } pmrcc_od_t;

    typedef struct packed {
        logic charger_on;
        logic precharge_current;
        logic charge_current_select;
        logic fault;
    } pmrcc_chg_t;

    typedef enum logic [2:0] {
        PMRCC_IDLE = 3'b000,
        PMRCC_PRE = 3'b001,
        PMRCC_FAST = 3'b010,
        PMRCC_REG = 3'b011,
        PMRCC_DONE = 3'b100,
        PMRCC_FAULT = 3'b101
    } pmrcc_chg_st_t;

endpackage : pmrcc_pkg

/* hdl/pmrcc_top.sv */
// Rail sequencing, reset generator and charge sequencer with an APB register slave.
// Assumes host pins and comparator results may change at any time; all are synchronised here.
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "pmrcc_regs.svh"

// How it works
// - Suspend input limits host current, always
// - Suspended host never feeds rails; adapter may
// - Battery-only and both enables low: standby
// - Enable high leaves standby; ready 1 ms later
// - Logic supply on with system rail; else discharge
// - Main enable switches second, three-volt, LED supply
// - Aux enable switches third regulator alone
// - External power: linear; battery only: boost
// - Suspended host counts as absent for boost
// - LED pins pull low, only with main enable
// - Motor pin pulls low while control high
// - Reset condition with 0.14 V hysteresis
// - Reset output rises late, falls at once
// - Reset condition forces switched outputs off
// - Low battery: pre-charge current, pre-charge timer
// - Pre-charge timeout: charger off, report fault
// - Current select on only for adapter alone
// - Regulation voltage moves fast charge to regulation
// - Charge timeout before termination: fault
// - Status pair encodes charge phase
// - Charge enable high halts charger
// - No charging unless power path permits
module pmrcc_top
    import pmrcc_pkg::*;
#(
    parameter int unsigned RST_DLY_CYC = `PMRCC_RST_DLY_CYC,
    parameter int unsigned READY_CYC = `PMRCC_READY_CYC,
    parameter logic [39:0] PRECHG_CYC = 40'(`PMRCC_PRECHG_CYC),
    parameter logic [39:0] CHG_CYC = 40'(`PMRCC_CHG_CYC)
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pmrcc_ctl_t ctl_pins,
    input wire pmrcc_ana_t ana_in,
    output pmrcc_rail_t rails,
    output pmrcc_path_t path,
    output pmrcc_chg_t chg,
    output pmrcc_od_t red_led_out,
    output pmrcc_od_t green_led_out,
    output pmrcc_od_t blue_led_out,
    output pmrcc_od_t motor_drive_out,
    output pmrcc_od_t charge_status_a,
    output pmrcc_od_t charge_status_b,
    output logic system_reset_n
);

    localparam int SYNC_W = $bits(pmrcc_ctl_t) + $bits(pmrcc_ana_t);

    if (RST_DLY_CYC < 2 || READY_CYC < 2 || RST_DLY_CYC > 32'h00FF_FFFF
        || READY_CYC > 32'h00FF_FFFF) begin : g_bad_dly
        $error("pmrcc_top: delay counts must lie in 2 .. 2^24-1");
    end
    if (PRECHG_CYC < 40'h2 || CHG_CYC < 40'h2) begin : g_bad_tmr
        $error("pmrcc_top: safety timer counts must be at least 2");
    end

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;

    // One flat vector keeps every generated index inside its source
    assign sync_in = {ctl_pins, ana_in};
    pmrcc_ctl_t ctl_s;
    pmrcc_ana_t ana_s;

    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                sync1_ff[i] <= 1'b0;
                sync2_ff[i] <= 1'b0;
            end else begin
                sync1_ff[i] <= sync_in[i];
                sync2_ff[i] <= sync1_ff[i];
            end
        end
    end

    assign ana_s = sync2_ff[$bits(pmrcc_ana_t)-1:0];
    assign ctl_s = sync2_ff[SYNC_W-1:$bits(pmrcc_ana_t)];

    // ------------------------------------------------------------------
    // Power path
    // ------------------------------------------------------------------
    logic host_src;
    logic ext_src;
    logic batt_only;
    logic nxt_standby;

    // a suspended host is not a source
    assign host_src = ana_s.host_power_good && !ctl_s.host_suspend;
    assign ext_src = host_src || ana_s.adapter_power_good;
    assign batt_only = !ext_src && ana_s.battery_present;
    assign nxt_standby = batt_only && !ctl_s.main_rail_enable && !ctl_s.aux_rail_enable;

    logic [23:0] ready_cnt_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            path <= '0;
        end else begin
            path.host_suspended <= ctl_s.host_suspend;
            path.host_feeds <= host_src;
            path.adapter_feeds <= ana_s.adapter_power_good && !host_src;
            path.standby <= nxt_standby;
            path.batt_low_r_switch <= batt_only && !nxt_standby;
            path.rails_ready <= !nxt_standby && ready_cnt_ff == 24'(READY_CYC - 1);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_cnt_ff <= '0;
        end else if (nxt_standby) begin
            ready_cnt_ff <= '0;
        end else if (ready_cnt_ff != 24'(READY_CYC - 1)) begin
            ready_cnt_ff <= ready_cnt_ff + 24'h1;
        end
    end

    // ------------------------------------------------------------------
    // Reset generator
    // ------------------------------------------------------------------
    logic rst_cond_ff;
    logic [23:0] rst_cnt_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_cond_ff <= 1'b1;
        end else if (ana_s.logic_supply_low) begin
            rst_cond_ff <= 1'b1;
        end else if (ana_s.logic_supply_high) begin
            rst_cond_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_cnt_ff <= '0;
            system_reset_n <= 1'b0;
        end else if (rst_cond_ff) begin
            rst_cnt_ff <= '0;
            system_reset_n <= 1'b0;
        end else if (rst_cnt_ff != 24'(RST_DLY_CYC - 1)) begin
            rst_cnt_ff <= rst_cnt_ff + 24'h1;
        end else begin
            system_reset_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Rails and switches
    // ------------------------------------------------------------------
    logic main_on;

    assign main_on = ctl_s.main_rail_enable && !rst_cond_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rails <= '0;
        end else begin
            rails.logic_supply_en <= ana_s.system_rail_good;
            rails.logic_discharge_en <= !ana_s.system_rail_good;
            rails.second_reg_en <= main_on;
            rails.three_volt_en <= main_on;
            rails.led_supply_en <= main_on;
            rails.third_reg_en <= ctl_s.aux_rail_enable && !rst_cond_ff;
            rails.linear_run <= main_on && ext_src;
            rails.boost_run <= main_on && !ext_src;
        end
    end

    // Open-drain pins only ever drive low
    assign red_led_out.o = 1'b0;
    assign green_led_out.o = 1'b0;
    assign blue_led_out.o = 1'b0;
    assign motor_drive_out.o = 1'b0;
    assign charge_status_a.o = 1'b0;
    assign charge_status_b.o = 1'b0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            red_led_out.oe <= 1'b0;
            green_led_out.oe <= 1'b0;
            blue_led_out.oe <= 1'b0;
            motor_drive_out.oe <= 1'b0;
        end else begin
            red_led_out.oe <= ctl_s.red_led_ctrl && ctl_s.main_rail_enable;
            green_led_out.oe <= ctl_s.green_led_ctrl && ctl_s.main_rail_enable;
            blue_led_out.oe <= ctl_s.blue_led_ctrl && ctl_s.main_rail_enable;
            motor_drive_out.oe <= ctl_s.motor_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // Charge sequencer
    // ------------------------------------------------------------------
    logic inhibit_ff;
    logic chg_ok;
    logic rch_armed_ff;
    logic pre_exp;
    logic chg_exp;
    logic [39:0] pre_cnt_ff;
    logic [39:0] chg_cnt_ff;
    pmrcc_chg_st_t st_ff;
    pmrcc_chg_st_t nxt_st;

    // enable pin, power path and software inhibit
    assign chg_ok = ext_src && !ctl_s.charge_enable_n && !inhibit_ff;
    assign pre_exp = pre_cnt_ff == PRECHG_CYC - 40'h1;
    assign chg_exp = chg_cnt_ff == CHG_CYC - 40'h1;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            PMRCC_IDLE: begin
                if (chg_ok) begin
                    nxt_st = ana_s.batt_low_v ? PMRCC_PRE : PMRCC_FAST;
                end
            end
            PMRCC_PRE: begin
                if (!chg_ok) begin
                    nxt_st = PMRCC_IDLE;
                end else if (pre_exp) begin
                    nxt_st = PMRCC_FAULT;
                end else if (!ana_s.batt_low_v) begin
                    nxt_st = PMRCC_FAST;
                end
            end
            PMRCC_FAST, PMRCC_REG: begin
                if (!chg_ok) begin
                    nxt_st = PMRCC_IDLE;
                end else if (chg_exp) begin
                    nxt_st = PMRCC_FAULT;
                end else if (st_ff == PMRCC_REG && ana_s.charge_term) begin
                    nxt_st = PMRCC_DONE;
                end else if (ana_s.batt_at_reg) begin
                    nxt_st = PMRCC_REG;
                end
            end
            PMRCC_DONE: begin
                if (!chg_ok || ana_s.batt_below_rch) begin
                    nxt_st = PMRCC_IDLE;
                end
            end
            PMRCC_FAULT: begin
                // Cleared by a charge enable toggle or a recharge-level drop
                if (ctl_s.charge_enable_n || (rch_armed_ff && ana_s.batt_below_rch)) begin
                    nxt_st = PMRCC_IDLE;
                end
            end
            default: begin
                nxt_st = PMRCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= PMRCC_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // A recharge-level drop clears a fault only after the battery was seen above recharge level
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rch_armed_ff <= 1'b0;
        end else if (st_ff != PMRCC_FAULT) begin
            rch_armed_ff <= 1'b0;
        end else if (!ana_s.batt_below_rch) begin
            rch_armed_ff <= 1'b1;
        end
    end

    // pre-charge timer runs in pre-charge only
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt_ff <= '0;
        end else if (st_ff == PMRCC_PRE && !pre_exp) begin
            pre_cnt_ff <= pre_cnt_ff + 40'h1;
        end else if (st_ff != PMRCC_PRE) begin
            pre_cnt_ff <= '0;
        end
    end

    // charge timer spans fast and regulation phases
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            chg_cnt_ff <= '0;
        end else if ((st_ff == PMRCC_FAST || st_ff == PMRCC_REG) && !chg_exp) begin
            chg_cnt_ff <= chg_cnt_ff + 40'h1;
        end else if (st_ff != PMRCC_FAST && st_ff != PMRCC_REG) begin
            chg_cnt_ff <= '0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            chg <= '0;
            charge_status_a.oe <= 1'b0;
            charge_status_b.oe <= 1'b0;
        end else begin
            chg.charger_on <= nxt_st == PMRCC_PRE || nxt_st == PMRCC_FAST
                || nxt_st == PMRCC_REG;
            chg.precharge_current <= nxt_st == PMRCC_PRE;
            chg.fault <= nxt_st == PMRCC_FAULT;
            chg.charge_current_select <= ana_s.adapter_power_good && !ana_s.host_power_good;
            charge_status_a.oe <= nxt_st == PMRCC_PRE || nxt_st == PMRCC_FAST
                || nxt_st == PMRCC_REG;
            charge_status_b.oe <= nxt_st == PMRCC_PRE || nxt_st == PMRCC_DONE;
        end
    end

    // ------------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------------
    logic hit_ctrl;
    logic hit_stat;

    assign hit_ctrl = paddr == `PMRCC_CTRL_OFS;
    assign hit_stat = paddr == `PMRCC_STATUS_OFS;
    assign pready = 1'b1;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            inhibit_ff <= 1'(`PMRCC_CTRL_RST >> `PMRCC_CTRL_INHIBIT_BIT);
        end else if (psel && penable && pwrite && hit_ctrl) begin
            inhibit_ff <= pwdata[`PMRCC_CTRL_INHIBIT_BIT];
        end
    end

    // Read data is staged in the setup cycle so the access cycle answers at once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !hit_ctrl && !hit_stat;
            if (!pwrite && hit_ctrl) begin
                prdata <= {31'h0, inhibit_ff};
            end else if (!pwrite && hit_stat) begin
                prdata <= {16'h0, 5'h0, st_ff, rst_cond_ff, system_reset_n,
                    path.standby, path.rails_ready, path.host_feeds,
                    path.adapter_feeds, chg.fault, ctl_s.host_suspend};
            end else begin
                prdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_susp_limit;
        @(posedge sys_clk) disable iff (!reset_n)
        ctl_pins.host_suspend [*3] |=> path.host_suspended && !path.host_feeds;
    endproperty
    a_susp_limit: assert property (p_susp_limit) else $error("suspend not honoured");

    property p_standby_rails;
        @(posedge sys_clk) disable iff (!reset_n)
        path.standby |-> !path.batt_low_r_switch && !path.rails_ready;
    endproperty
    a_standby_rails: assert property (p_standby_rails) else $error("standby inconsistent");

    property p_ready_late;
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(path.standby) |-> !path.rails_ready [*8];
    endproperty
    a_ready_late: assert property (p_ready_late) else $error("rails ready too early");

    property p_main_group;
        @(posedge sys_clk) disable iff (!reset_n)
        rails.led_supply_en |-> rails.second_reg_en && rails.three_volt_en
            && (rails.boost_run != rails.linear_run);
    endproperty
    a_main_group: assert property (p_main_group) else $error("main rail group split");

    property p_led_gate;
        @(posedge sys_clk) disable iff (!reset_n)
        !ctl_pins.main_rail_enable [*4] |=> !red_led_out.oe && !green_led_out.oe
            && !blue_led_out.oe;
    endproperty
    a_led_gate: assert property (p_led_gate) else $error("LED active without enable");

    property p_rst_fast;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(rst_cond_ff) |=> !system_reset_n && !rails.led_supply_en && !rails.third_reg_en;
    endproperty
    a_rst_fast: assert property (p_rst_fast) else $error("reset not immediate");

    sequence s_cond_released;
        $fell(rst_cond_ff);
    endsequence

    property p_rst_slow;
        @(posedge sys_clk) disable iff (!reset_n)
        s_cond_released |-> !system_reset_n [*2];
    endproperty
    a_rst_slow: assert property (p_rst_slow) else $error("reset released early");

    sequence s_pre_timeout;
        st_ff == PMRCC_PRE && pre_exp && chg_ok;
    endsequence

    sequence s_fault_shown;
        st_ff == PMRCC_FAULT && !chg.charger_on ##0 !charge_status_a.oe && !charge_status_b.oe;
    endsequence

    property p_pre_fault;
        @(posedge sys_clk) disable iff (!reset_n)
        s_pre_timeout |=> s_fault_shown;
    endproperty
    a_pre_fault: assert property (p_pre_fault) else $error("pre-charge timeout missed");

    property p_status_pre;
        @(posedge sys_clk) disable iff (!reset_n)
        chg.precharge_current |-> charge_status_a.oe && charge_status_b.oe && chg.charger_on;
    endproperty
    a_status_pre: assert property (p_status_pre) else $error("status pair wrong");

    property p_no_charge;
        @(posedge sys_clk) disable iff (!reset_n)
        !chg_ok |=> !chg.charger_on;
    endproperty
    a_no_charge: assert property (p_no_charge) else $error("charger on when not allowed");

endmodule : pmrcc_top

/* tb/pmrcc_host.sv */
// Host processor model: drives the logic pins of the controller.
// Assumes one system clock; pins change just after its rising edge.
module pmrcc_host
    import pmrcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire pmrcc_ctl_t want,
    output pmrcc_ctl_t ctl_pins
);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_pins <= 8'h01;
        end else begin
            ctl_pins <= want;
        end
    end
endmodule : pmrcc_host

/* tb/pmrcc_bench.sv */
// Bench of the rail and charge controller: pins, reset output, charger, APB.
// Assumes shortened counts and a three-edge pin latency plus one host edge.
`define CHK(n, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("ERROR %s expected %h seen %h", n, e, g); \
    end \
end
module pmrcc_bench
    import pmrcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int id; logic [31:0] m; logic [31:0] e;} pmrcc_note_t;
    logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v, lfsr = 32'h0001_11FE;
    logic pready, pslverr, er, hu, us, system_reset_n;
    pmrcc_ctl_t cmd, ctl_pins;
    pmrcc_ana_t ana;
    pmrcc_rail_t rails;
    pmrcc_path_t path;
    pmrcc_chg_t chg;
    pmrcc_od_t lr, lg, lb, mt, sa, sb;
    pmrcc_note_t q[$], n;
    int err_count = 0, samples_checked = 0, k;
    logic [2:0] pw [5] = '{3'h4, 3'h2, 3'h6, 3'h5, 3'h7};
    string fname [7] = '{"rails", "path", "chg", "pins", "reset_out", "apb_data", "apb_err"};

    pmrcc_host host (.sys_clk(sys_clk), .reset_n(reset_n), .want(cmd), .ctl_pins(ctl_pins));
    pmrcc_top #(.RST_DLY_CYC(20), .READY_CYC(10), .PRECHG_CYC(40'h32), .CHG_CYC(40'h64)) uut (
        .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctl_pins(ctl_pins), .ana_in(ana), .rails(rails), .path(path), .chg(chg),
        .red_led_out(lr), .green_led_out(lg), .blue_led_out(lb), .motor_drive_out(mt),
        .charge_status_a(sa), .charge_status_b(sb), .system_reset_n(system_reset_n));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] nxt_rand(logic [31:0] s);
        nxt_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt_rand

    function automatic logic [31:0] seen(int id);
        case (id)
            0: seen = 32'(rails);
            1: seen = 32'(path);
            2: seen = 32'(chg);
            3: seen = 32'({lr.oe, lg.oe, lb.oe, mt.oe, sa.oe, sb.oe});
            4: seen = 32'(system_reset_n);
            5: seen = rd;
            default: seen = 32'(er);
        endcase
    endfunction : seen

    // ----------------------------------------------------------------
    // Result watcher: oldest note first
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            `CHK(fname[n.id], n.e, seen(n.id) & n.m)
        end
    end

    task automatic ex(int id, logic [31:0] m, logic [31:0] e);
        q.push_back('{id, m, e});
    endtask : ex

    task automatic drive(logic [7:0] c, logic [9:0] a, int w);
        @(posedge sys_clk);
        cmd <= c;
        ana <= a;
        repeat (w) @(posedge sys_clk);
    endtask : drive

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Request held until pready is seen high at a rising edge
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int i;
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            err_count++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    initial begin
        cmd = 8'h01;
        ana = 10'h0D0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        ex(4, 32'h1, 32'h0);
        repeat (20) @(posedge sys_clk);
        ex(4, 32'h1, 32'h1);
        ex(0, 32'hC0, 32'h80);
        ex(1, 32'h04, 32'h04);
        $display("test reset done");
        for (k = 0; k < 8; k++) begin
            lfsr = nxt_rand(lfsr);
            v = lfsr & 32'h7E;
            drive(v[7:0], 10'h0D0, 15);
            ex(0, 32'h3C, 32'({v[6], v[5], v[6], v[6], 2'b00}));
            ex(1, 32'h07, 32'({!(v[6] | v[5]), v[6] | v[5], v[6] | v[5]}));
            ex(3, 32'h3C, 32'({v[4:2] & {3{v[6]}}, v[1], 2'b00}));
            ex(2, 32'h8, 32'h0);
        end
        $display("test rails done");
        for (k = 0; k < 5; k++) begin
            v = 32'(pw[k]);
            hu = v[2] & !v[0];
            us = hu | v[1];
            drive({v[0], 7'h41}, {v[2:1], 8'hD0}, 8);
            ex(0, 32'h03, us ? 32'h1 : 32'h2);
            ex(1, 32'h38, 32'({v[0], hu, v[1] & !hu, 3'b000}));
            ex(2, 32'h2, 32'({v[1] & !v[2], 1'b0}));
        end
        $display("test sources done");
        drive(8'h40, 10'h1D8, 8);
        ex(2, 32'hD, 32'hC);
        ex(3, 32'h3, 32'h3);
        repeat (60) @(posedge sys_clk);
        ex(2, 32'h9, 32'h1);
        ex(3, 32'h3, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        ex(5, 32'h702, 32'h502);
        drive(8'h41, 10'h1D0, 8);
        ex(2, 32'h9, 32'h0);
        apb(1'b1, 12'h000, 32'h1);
        drive(8'h40, 10'h1D0, 8);
        apb(1'b0, 12'h000, 32'h0);
        ex(5, 32'hFFFF_FFFF, 32'h1);
        ex(2, 32'h8, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        repeat (8) @(posedge sys_clk);
        ex(2, 32'hD, 32'h8);
        ex(3, 32'h3, 32'h2);
        drive(8'h40, 10'h1D4, 8);
        apb(1'b0, 12'h004, 32'h0);
        ex(5, 32'h700, 32'h300);
        repeat (110) @(posedge sys_clk);
        ex(2, 32'h9, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        ex(6, 32'h1, 32'h1);
        ex(5, 32'hFFFF_FFFF, 32'h0);
        $display("test charger done");
        drive(8'h41, 10'h0E0, 8);
        ex(4, 32'h1, 32'h0);
        ex(0, 32'h20, 32'h0);
        drive(8'h41, 10'h0C0, 40);
        ex(4, 32'h1, 32'h0);
        drive(8'h41, 10'h0D0, 30);
        ex(4, 32'h1, 32'h1);
        ex(0, 32'h20, 32'h20);
        repeat (2) @(posedge sys_clk);
        $display("test reset output done");
        wrap_up();
    end
endmodule : pmrcc_bench
